// ===== rtl/dbgc_pkg.sv
// Purpose: Shared constants for the debug bus comparator block.
// Assumes: Register index times four gives the APB byte address.
// Notes: Sequencer state type lives here for all files.
package dbgc_pkg;
  // Register indices
  localparam logic [5:0] IDX_CONTROL_ONE = 6'h20;
  localparam logic [5:0] IDX_CONTROL_TWO = 6'h21;
  localparam logic [5:0] IDX_STATUS = 6'h22;
  localparam logic [5:0] IDX_COMP_CONTROL = 6'h28;
  localparam logic [5:0] IDX_ADDR_HIGH = 6'h29;
  localparam logic [5:0] IDX_ADDR_MID = 6'h2A;
  localparam logic [5:0] IDX_ADDR_LOW = 6'h2B;
  localparam logic [5:0] IDX_DATA_HIGH = 6'h2C;
  localparam logic [5:0] IDX_DATA_LOW = 6'h2D;
  localparam logic [5:0] IDX_DATA_HIGH_MASK = 6'h2E;
  localparam logic [5:0] IDX_DATA_LOW_MASK = 6'h2F;
  // Control one fields
  localparam int C1_ARM = 7;
  localparam int C1_FIRE = 6;
  localparam int C1_BRK = 5;
  localparam int C1_TRACE = 4;
  localparam int C1_SEL_LSB = 0;
  // Comparator control fields
  localparam int CC_ENABLE = 0;
  localparam int CC_TAG = 1;
  localparam int CC_DIR_READ = 2;
  localparam int CC_DIR_CHECK = 3;
  localparam int CC_SIZE_BYTE = 4;
  localparam int CC_SIZE_CHECK = 5;
  localparam int CC_DIFF = 6;
  // Status fields
  localparam int ST_FINAL = 0;
  localparam int ST_MATCH_LSB = 1;
  localparam int ST_ARMED = 4;
  // Reset values
  localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0] CONTROL_TWO_RST = 8'h00;
  localparam logic [7:0] COMP_CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  // Selector and range codes
  localparam logic [1:0] SEL_A = 2'h0;
  localparam logic [1:0] SEL_NONE = 2'h3;
  localparam logic [1:0] RANGE_INSIDE = 2'h1;
  localparam logic [1:0] RANGE_OUTSIDE = 2'h2;
  // Sequencer states
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_FINAL} dbgc_seq_e;
endpackage

// ===== rtl/dbgc_bus_if.sv
// Purpose: Carries the qualified core bus cycle to the comparators.
// Assumes: One bus cycle per clock when valid is high.
// Notes: Byte data rides on bits 15:8.
`timescale 1ns/100ps
`default_nettype none
interface dbgc_bus_if #(parameter int ADDR_W = 18);
  logic [ADDR_W-1:0] addr;
  logic [15:0] data;
  logic valid;
  logic read;
  logic byte_acc;
  modport src (output addr, data, valid, read, byte_acc);
  modport snk (input addr, data, valid, read, byte_acc);
endinterface
`default_nettype wire

// ===== rtl/dbgc_comparator.sv
// Purpose: One address comparator with optional size and data checks.
// Assumes: Control byte layout from the package.
// Notes: Outputs are combinational; the top registers results.
`timescale 1ns/100ps
`default_nettype none
module dbgc_comparator
  import dbgc_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter bit HAS_SIZE = 1'b0,
  parameter bit HAS_DATA = 1'b0
)
(
  // Bus cycle
  dbgc_bus_if.snk bus,
  // Settings
  input wire logic [7:0] ctrl,
  input wire logic [ADDR_W-1:0] cmp_addr,
  input wire logic [15:0] cmp_data,
  input wire logic [15:0] cmp_mask,
  input wire logic range_mode,
  // Results
  output logic addr_eq,
  output logic addr_lt,
  output logic addr_gt,
  output logic qual_ok
);
  logic dir_ok;
  logic size_ok;
  logic data_ok;
  logic [15:0] diff_bits;

  // Address relations; equal, below and above for range use
  assign addr_eq = bus.addr == cmp_addr;
  assign addr_lt = bus.addr < cmp_addr;
  assign addr_gt = bus.addr > cmp_addr;

  // Direction and size qualifiers
  assign dir_ok = !ctrl[CC_DIR_CHECK] || (bus.read == ctrl[CC_DIR_READ]);
  assign size_ok = !HAS_SIZE || range_mode || !ctrl[CC_SIZE_CHECK]
    || (bus.byte_acc == ctrl[CC_SIZE_BYTE]);

  // Masked data compare; high byte is the lower address
  assign diff_bits = (bus.data ^ cmp_data) & cmp_mask;
  assign data_ok = !HAS_DATA ? 1'b1
    : (ctrl[CC_DIFF] ? |diff_bits : ~|diff_bits);

  // Tagged mode drops all qualifiers
  assign qual_ok = ctrl[CC_TAG] ? 1'b1 : (dir_ok && size_ok && data_ok);
endmodule
`default_nettype wire

// ===== rtl/dbgc_sequencer.sv
// Purpose: Reduced state sequencer reaching the final state.
// Assumes: Hits arrive already gated by arming.
// Notes: Final holds until software disarms.
`timescale 1ns/100ps
`default_nettype none
module dbgc_sequencer
  import dbgc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic armed,
  input wire logic fire,
  input wire logic [2:0] hit,
  input wire logic brk_en,
  input wire logic trace_en,
  input wire logic secure,
  // Results
  output logic final_reg,
  output logic brk_reg,
  output logic trace_reg
);
  dbgc_seq_e state_reg;
  dbgc_seq_e state_next;
  logic enter_final;

  // Final entry on a hit or an immediate fire
  assign enter_final = (state_reg != SEQ_FINAL) && armed && ((|hit) || fire);

  // Next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SEQ_IDLE: if (enter_final) state_next = SEQ_FINAL;
        else if (armed) state_next = SEQ_WAIT;
      SEQ_WAIT: if (!armed) state_next = SEQ_IDLE;
        else if (enter_final) state_next = SEQ_FINAL;
      SEQ_FINAL: if (!armed) state_next = SEQ_IDLE;
      default: state_next = SEQ_IDLE;
    endcase
  end

  // State and one-cycle action pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= SEQ_IDLE;
      final_reg <= 1'b0;
      brk_reg <= 1'b0;
      trace_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      final_reg <= state_next == SEQ_FINAL;
      brk_reg <= enter_final && brk_en;
      trace_reg <= enter_final && trace_en && !secure;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/dbgc_top.sv
// Purpose: Debug comparators, register file and match routing.
// Assumes: APB slave; core bus signals synchronous to pclk.
// Notes: One wait state on every APB access.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module dbgc_top
  import dbgc_pkg::*;
#(
  parameter int ADDR_W = 18
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core bus
  input wire logic [ADDR_W-1:0] core_addr,
  input wire logic [15:0] core_data,
  input wire logic core_valid,
  input wire logic core_read,
  input wire logic core_byte,
  input wire logic core_fetch,
  // Core state and tag return
  input wire logic core_bdm_active,
  input wire logic core_secure,
  input wire logic [2:0] core_taghit,
  // Debug outputs
  output logic [2:0] tag_attach,
  output logic [2:0] match_out,
  output logic final_state,
  output logic breakpoint_req,
  output logic trace_start
);
  localparam int HI_W = ADDR_W - 16;

  dbgc_bus_if #(.ADDR_W(ADDR_W)) bus_if ();

  // Registers
  logic [7:0] control_one_reg;
  logic [7:0] control_two_reg;
  logic [7:0] comp_control_reg [3];
  logic [ADDR_W-1:0] compare_address_reg [3];
  logic [7:0] data_high_compare_reg;
  logic [7:0] data_low_compare_reg;
  logic [7:0] data_high_compare_mask_reg;
  logic [7:0] data_low_compare_mask_reg;
  logic [2:0] match_flags_reg;
  logic fire_reg;
  logic [2:0] tag_attach_reg;
  logic [2:0] match_out_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // Comparator results
  logic [2:0] eq;
  logic [2:0] lt;
  logic [2:0] gt;
  logic [2:0] qual;
  logic [2:0] en;
  logic [2:0] tag;

  // Decode wires
  logic [5:0] idx;
  logic [1:0] sel;
  logic armed;
  logic sel_a;
  logic sel_ok;
  logic access;
  logic commit;
  logic wr;
  logic mapped;
  logic wr_c1;
  logic wr_c2;
  logic wr_locked;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [1:0] range_sel;
  logic range_on;
  logic in_range;
  logic out_range;
  logic range_hit;
  logic [2:0] forced;
  logic [2:0] tag_now;
  logic [2:0] match_now;
  logic [2:0] taghit_ok;
  logic [2:0] hit;

  // Byte of a stored address, by register index
  function automatic logic [7:0] addr_byte(input logic [ADDR_W-1:0] a,
                                           input logic [5:0] i);
    logic [7:0] r;
    r = 8'h00;
    if (i == IDX_ADDR_HIGH)
      r[HI_W-1:0] = a[ADDR_W-1:16];
    else if (i == IDX_ADDR_MID)
      r = a[15:8];
    else if (i == IDX_ADDR_LOW)
      r = a[7:0];
    return r;
  endfunction

  // Bus cycle presented to the comparators, muted in background debug
  assign bus_if.addr = core_addr;
  assign bus_if.data = core_data;
  assign bus_if.valid = core_valid && !core_bdm_active;
  assign bus_if.read = core_read;
  assign bus_if.byte_acc = core_byte;

  // Three comparators; only A carries data, only A and B size
  for (genvar g = 0; g < 3; g++)
  begin : g_cmp
    dbgc_comparator #(
      .ADDR_W(ADDR_W),
      .HAS_SIZE(g < 2),
      .HAS_DATA(g == 0)
    ) u_cmp (
      .bus(bus_if.snk),
      .ctrl(comp_control_reg[g]),
      .cmp_addr(compare_address_reg[g]),
      .cmp_data({data_high_compare_reg, data_low_compare_reg}),
      .cmp_mask({data_high_compare_mask_reg, data_low_compare_mask_reg}),
      .range_mode(range_on),
      .addr_eq(eq[g]),
      .addr_lt(lt[g]),
      .addr_gt(gt[g]),
      .qual_ok(qual[g])
    );
    assign en[g] = comp_control_reg[g][CC_ENABLE];
    assign tag[g] = comp_control_reg[g][CC_TAG];
  end

  // Range decode; A supplies direction, data and tag for the pair
  assign range_sel = control_two_reg[1:0];
  assign range_on = (range_sel == RANGE_INSIDE) || (range_sel == RANGE_OUTSIDE);
  assign in_range = gt[0] && lt[1];
  assign out_range = lt[0] || gt[1];
  assign range_hit = bus_if.valid && en[0] && en[1] && qual[0]
    && ((range_sel == RANGE_INSIDE) ? in_range : out_range);

  // Forced matches on the bus cycle itself
  assign forced[0] = range_on ? (range_hit && !tag[0])
    : (bus_if.valid && en[0] && !tag[0] && eq[0] && qual[0]);
  assign forced[1] = !range_on && bus_if.valid && en[1] && !tag[1] && eq[1] && qual[1];
  assign forced[2] = bus_if.valid && en[2] && !tag[2] && eq[2] && qual[2];

  // Tags attach to fetched opcodes at the exact address, or anywhere inside or outside the range, per range_sel, for A in range mode
  assign tag_now[0] = core_fetch && (range_on ? (range_hit && tag[0])
    : (bus_if.valid && en[0] && tag[0] && eq[0]));
  assign tag_now[1] = core_fetch && !range_on && bus_if.valid && en[1] && tag[1] && eq[1];
  assign tag_now[2] = core_fetch && bus_if.valid && en[2] && tag[2] && eq[2];

  // Tag hits count only when the core executes the tagged opcode
  assign taghit_ok = core_taghit & tag & en & {3{!core_bdm_active}};
  assign match_now = forced | taghit_ok;
  assign hit = armed ? match_now : 3'h0;

  // APB decode
  assign idx = paddr[7:2];
  assign sel = control_one_reg[C1_SEL_LSB +: 2];
  assign armed = control_one_reg[C1_ARM];
  assign sel_a = sel == SEL_A;
  assign sel_ok = sel != SEL_NONE;
  assign access = psel && penable && !pready_reg;
  assign commit = psel && penable && pready_reg;
  assign wr = commit && pwrite;
  assign wbyte = pwdata[7:0];
  assign wr_c1 = wr && (idx == IDX_CONTROL_ONE);
  assign wr_c2 = wr && (idx == IDX_CONTROL_TWO) && !armed;
  assign wr_locked = wr && !armed && sel_ok;
  assign mapped = (idx >= IDX_CONTROL_ONE && idx <= IDX_STATUS)
    || (idx >= IDX_COMP_CONTROL && idx <= IDX_DATA_LOW_MASK);

  // Read data selection; data registers hidden unless A is selected
  always_comb
  begin
    rbyte = 8'h00;
    case (idx)
      IDX_CONTROL_ONE: rbyte = control_one_reg;
      IDX_CONTROL_TWO: rbyte = control_two_reg;
      IDX_STATUS:
      begin
        rbyte[ST_FINAL] = final_state;
        rbyte[ST_MATCH_LSB +: 3] = match_flags_reg;
        rbyte[ST_ARMED] = armed;
      end
      IDX_COMP_CONTROL: rbyte = sel_ok ? comp_control_reg[sel] : 8'h00;
      IDX_ADDR_HIGH, IDX_ADDR_MID, IDX_ADDR_LOW:
        rbyte = sel_ok ? addr_byte(compare_address_reg[sel], idx) : 8'h00;
      IDX_DATA_HIGH: rbyte = sel_a ? data_high_compare_reg : 8'h00;
      IDX_DATA_LOW: rbyte = sel_a ? data_low_compare_reg : 8'h00;
      IDX_DATA_HIGH_MASK: rbyte = sel_a ? data_high_compare_mask_reg : 8'h00;
      IDX_DATA_LOW_MASK: rbyte = sel_a ? data_low_compare_mask_reg : 8'h00;
      default: rbyte = 8'h00;
    endcase
  end

  // APB handshake: pready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= access;
      pslverr_reg <= access && !mapped;
      prdata_reg <= (access && !pwrite) ? {24'h00_0000, rbyte} : 32'h0000_0000;
    end
  end

  // Global controls; fire bit is a write pulse, never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_one_reg <= CONTROL_ONE_RST;
      control_two_reg <= CONTROL_TWO_RST;
      fire_reg <= 1'b0;
    end
    else
    begin
      if (wr_c1)
        control_one_reg <= {wbyte[7], 1'b0, wbyte[5:0]};
      if (wr_c2)
        control_two_reg <= wbyte;
      fire_reg <= wr_c1 && wbyte[C1_FIRE] && wbyte[C1_ARM];
    end
  end

  // Comparator control and address, written through the selector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 3; i++)
      begin
        comp_control_reg[i] <= COMP_CONTROL_RST;
        compare_address_reg[i] <= '0;
      end
    end
    else if (wr_locked)
    begin
      if (idx == IDX_COMP_CONTROL)
        comp_control_reg[sel] <= wbyte;
      if (idx == IDX_ADDR_HIGH)
        compare_address_reg[sel][ADDR_W-1:16] <= wbyte[HI_W-1:0];
      if (idx == IDX_ADDR_MID)
        compare_address_reg[sel][15:8] <= wbyte;
      if (idx == IDX_ADDR_LOW)
        compare_address_reg[sel][7:0] <= wbyte;
    end
  end

  // Data compare and mask registers, A only and unarmed only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_high_compare_reg <= DATA_RST;
      data_low_compare_reg <= DATA_RST;
      data_high_compare_mask_reg <= MASK_RST;
      data_low_compare_mask_reg <= MASK_RST;
    end
    else if (wr_locked && sel_a)
    begin
      if (idx == IDX_DATA_HIGH)
        data_high_compare_reg <= wbyte;
      if (idx == IDX_DATA_LOW)
        data_low_compare_reg <= wbyte;
      if (idx == IDX_DATA_HIGH_MASK)
        data_high_compare_mask_reg <= wbyte;
      if (idx == IDX_DATA_LOW_MASK)
        data_low_compare_mask_reg <= wbyte;
    end
  end

  // Sticky match flags; arming clears them, since hit is zero while unarmed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      match_flags_reg <= 3'h0;
    else if (wr_c1 && wbyte[C1_ARM] && !armed)
      match_flags_reg <= hit;
    else
      match_flags_reg <= match_flags_reg | hit;
  end

  // Registered tag and match outputs; each match is a one-shot event
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tag_attach_reg <= 3'h0;
      match_out_reg <= 3'h0;
    end
    else
    begin
      tag_attach_reg <= armed ? tag_now : 3'h0;
      match_out_reg <= hit;
    end
  end

  // Final state, breakpoint and trace start
  dbgc_sequencer u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .armed(armed),
    .fire(fire_reg),
    .hit(hit),
    .brk_en(control_one_reg[C1_BRK]),
    .trace_en(control_one_reg[C1_TRACE]),
    .secure(core_secure),
    .final_reg(final_state),
    .brk_reg(breakpoint_req),
    .trace_reg(trace_start)
  );

  // Output drive
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tag_attach = tag_attach_reg;
  assign match_out = match_out_reg;
endmodule
`default_nettype wire

// ===== verification/dbgc_monitor.sv
// Purpose: Port-level checks of the debug comparator block.
// Assumes: One clock domain; presetn clears every output.
// Notes: Attached by bind from the bench top file.
`timescale 1ns/100ps
`default_nettype none
module dbgc_monitor
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core side
  input wire logic core_valid,
  input wire logic core_fetch,
  input wire logic core_bdm_active,
  input wire logic core_secure,
  input wire logic [2:0] core_taghit,
  // Debug outputs
  input wire logic [2:0] tag_attach,
  input wire logic [2:0] match_out,
  input wire logic final_state,
  input wire logic breakpoint_req,
  input wire logic trace_start
);
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // APB answer timing and read data
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready high for more than one cycle");
  apb_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside an answer");
  // Match causes
  bdm_mute_a: assert property (core_valid && core_bdm_active && core_taghit == 3'h0
    |=> match_out == 3'h0 && tag_attach == 3'h0)
    else $error("match during background debug");
  match_cause_a: assert property (match_out != 3'h0
    |-> $past(core_valid && !core_bdm_active) || $past(core_taghit) != 3'h0)
    else $error("match without a bus cycle or tag hit");
  tag_cause_a: assert property (tag_attach != 3'h0 |-> $past(core_valid && core_fetch))
    else $error("tag attached without a fetch");
  // Final state effects
  brk_entry_a: assert property (breakpoint_req |-> $rose(final_state))
    else $error("breakpoint not on final entry");
  trace_secure_a: assert property (trace_start |-> $rose(final_state) && !$past(core_secure))
    else $error("trace start in secure mode or off final entry");
  final_hold_a: assert property ($fell(final_state)
    |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("final state left without a register write");
endmodule
`default_nettype wire

// ===== verification/dbgc_core_model.sv
// Purpose: Behavioural processor core driving the watched buses.
// Assumes: Bench calls cyc for each bus cycle and sets the state levels.
// Notes: Released address and data lines carry inverted values so stale data never matches.
`timescale 1ns/100ps
`default_nettype none
module dbgc_core_model #(
  parameter int ADDR_W = 18
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Tag feedback
  input wire logic [2:0] tag_attach,
  // Core bus
  output logic [ADDR_W-1:0] core_addr,
  output logic [15:0] core_data,
  output logic core_valid,
  output logic core_read,
  output logic core_byte,
  output logic core_fetch,
  // Core state and tag return
  output logic core_bdm_active,
  output logic core_secure,
  output logic [2:0] core_taghit
);
  logic exec_en = 1'b0;
  logic halted = 1'b0;
  logic sec = 1'b0;
  logic [2:0] q1;
  logic [2:0] q2;

  // Core state levels chosen by the bench
  assign core_bdm_active = halted;
  assign core_secure = sec;

  initial
  begin
    core_addr = '0;
    core_data = 16'h0000;
    core_valid = 1'b0;
    core_read = 1'b0;
    core_byte = 1'b0;
    core_fetch = 1'b0;
  end

  // One bus cycle, then release with scrambled lines
  task automatic cyc(input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic r,
                     input logic b, input logic f);
    @(posedge pclk);
    core_addr <= a;
    core_data <= d;
    core_read <= r;
    core_byte <= b;
    core_fetch <= f;
    core_valid <= 1'b1;
    @(posedge pclk);
    core_valid <= 1'b0;
    core_addr <= ~a;
    core_data <= ~d;
  endtask

  // Tagged opcodes reach execute three cycles after the tag, if executed
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q1 <= 3'h0;
      q2 <= 3'h0;
      core_taghit <= 3'h0;
    end
    else
    begin
      q1 <= exec_en ? tag_attach : 3'h0;
      q2 <= q1;
      core_taghit <= q2;
    end
  end
endmodule
`default_nettype wire

// ===== verification/test_debug_bus_comparator_match.sv
// Purpose: Self-checking bench for the debug comparator block.
// Assumes: APB byte address is four times the register index.
// Notes: Each scenario disarms before it returns.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) \
  begin \
    checks++; \
    if ((a) !== (e)) \
    begin \
      bad_count++; \
      $display("[ERR] %s exp %0h got %0h", n, e, a); \
    end \
  end
module test_debug_bus_comparator_match;
  import dbgc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, core_valid, core_read, core_byte, core_fetch;
  logic core_bdm_active, core_secure, final_state, breakpoint_req, trace_start, bk, sb, st;
  logic [17:0] core_addr;
  logic [15:0] core_data;
  logic [2:0] core_taghit, tag_attach, match_out, mo, ta;
  int bad_count = 0;
  int checks = 0;
  int cyc_count = 0;

  dbgc_top u_dbgc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_addr(core_addr), .core_data(core_data), .core_valid(core_valid),
    .core_read(core_read), .core_byte(core_byte), .core_fetch(core_fetch),
    .core_bdm_active(core_bdm_active), .core_secure(core_secure), .core_taghit(core_taghit),
    .tag_attach(tag_attach), .match_out(match_out), .final_state(final_state),
    .breakpoint_req(breakpoint_req), .trace_start(trace_start));
  dbgc_core_model u_dbgc_core_model (.pclk(pclk), .presetn(presetn), .tag_attach(tag_attach),
    .core_addr(core_addr), .core_data(core_data), .core_valid(core_valid),
    .core_read(core_read), .core_byte(core_byte), .core_fetch(core_fetch),
    .core_bdm_active(core_bdm_active), .core_secure(core_secure), .core_taghit(core_taghit));

  // Clock and hang guard
  always #25 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc_count++;
    if (cyc_count == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end

  // APB transfer held until pready is sampled
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rd(input logic [5:0] i);
    apb(1'b0, i, 8'h00);
  endtask
  // Select a comparator and load its control and address
  task automatic cfg(input logic [1:0] s, input logic [7:0] c, input logic [17:0] a);
    wr(IDX_CONTROL_ONE, {6'h00, s});
    wr(IDX_COMP_CONTROL, c);
    wr(IDX_ADDR_HIGH, {6'h00, a[17:16]});
    wr(IDX_ADDR_MID, a[15:8]);
    wr(IDX_ADDR_LOW, a[7:0]);
  endtask
  // One core cycle and the registered answer after it
  task automatic hit(input logic [17:0] a, input logic [15:0] d, input logic r, input logic b,
                     input logic f);
    u_dbgc_core_model.cyc(a, d, r, b, f);
    @(posedge pclk);
    mo = match_out;
    ta = tag_attach;
    bk = breakpoint_req;
  endtask
  task automatic watch(input int n);
    sb = 1'b0;
    st = 1'b0;
    repeat (n)
    begin
      @(posedge pclk);
      if (breakpoint_req === 1'b1) sb = 1'b1;
      if (trace_start === 1'b1) st = 1'b1;
    end
  endtask

  task automatic t_regs();
    rd(IDX_DATA_HIGH_MASK);
    `CHK("mask_hi_rst", 32'h0, rdat)
    rd(IDX_DATA_LOW_MASK);
    `CHK("mask_lo_rst", 32'h0, rdat)
    rd(6'h00);
    `CHK("unmapped_err", 1'b1, rerr)
    wr(IDX_DATA_HIGH_MASK, 8'hC3);
    rd(IDX_DATA_HIGH_MASK);
    `CHK("mask_rw", 32'hC3, rdat)
    wr(IDX_CONTROL_ONE, 8'h01);
    rd(IDX_DATA_HIGH_MASK);
    `CHK("mask_sel_b", 32'h0, rdat)
    wr(IDX_CONTROL_ONE, 8'h80);
    wr(IDX_DATA_LOW_MASK, 8'h3C);
    wr(IDX_CONTROL_ONE, 8'h00);
    rd(IDX_DATA_LOW_MASK);
    `CHK("mask_armed", 32'h0, rdat)
    $display("t_regs done");
  endtask

  task automatic t_data();
    cfg(2'h0, 8'h01, 18'h00100);
    wr(IDX_DATA_HIGH, 8'h5A);
    wr(IDX_DATA_LOW, 8'hA5);
    wr(IDX_DATA_HIGH_MASK, 8'hFF);
    wr(IDX_CONTROL_ONE, 8'hA0);
    hit(18'h00100, 16'h5A00, 1'b0, 1'b0, 1'b0);
    `CHK("a_hi_eq", 3'h1, mo)
    `CHK("a_brk", 1'b1, bk)
    hit(18'h00100, 16'h5B00, 1'b0, 1'b0, 1'b0);
    `CHK("a_hi_ne", 3'h0, mo)
    wr(IDX_CONTROL_ONE, 8'h00);
    wr(IDX_DATA_HIGH_MASK, 8'h00);
    wr(IDX_DATA_LOW_MASK, 8'h0F);
    wr(IDX_CONTROL_ONE, 8'h80);
    hit(18'h00100, 16'hFFF5, 1'b1, 1'b0, 1'b0);
    `CHK("a_lo_eq", 3'h1, mo)
    hit(18'h00100, 16'h00A4, 1'b1, 1'b0, 1'b0);
    `CHK("a_lo_ne", 3'h0, mo)
    wr(IDX_CONTROL_ONE, 8'h00);
    wr(IDX_COMP_CONTROL, 8'h03);
    wr(IDX_CONTROL_ONE, 8'h80);
    hit(18'h00100, 16'h0000, 1'b1, 1'b0, 1'b1);
    `CHK("a_tag", 3'h1, ta)
    `CHK("a_tag_nomatch", 3'h0, mo)
    wr(IDX_CONTROL_ONE, 8'h00);
    wr(IDX_DATA_LOW_MASK, 8'h00);
    $display("t_data done");
  endtask

  task automatic t_qual();
    logic [7:0] ctl [6] = '{8'h09, 8'h09, 8'h0D, 8'h21, 8'h31, 8'h31};
    logic [5:0] rv = 6'b000110;
    logic [5:0] bv = 6'b101000;
    logic [5:0] ev = 6'b100101;
    for (int i = 0; i < 6; i++)
    begin
      cfg(2'h1, ctl[i], 18'h00200);
      wr(IDX_CONTROL_ONE, 8'h81);
      hit(18'h00200, 16'h1234, rv[i], bv[i], 1'b0);
      `CHK("b_qual", ev[i], mo[1])
      hit(18'h001FF, 16'h1234, rv[i], 1'b0, 1'b0);
      `CHK("b_word_below", 1'b0, mo[1])
    end
    cfg(2'h1, 8'h00, 18'h00000);
    $display("t_qual done");
  endtask

  task automatic t_fire();
    u_dbgc_core_model.sec <= 1'b1;
    wr(IDX_CONTROL_ONE, 8'hB0);
    wr(IDX_CONTROL_ONE, 8'hF0);
    watch(4);
    `CHK("fire_final", 1'b1, final_state)
    `CHK("secure_brk", 1'b1, sb)
    `CHK("secure_trace", 1'b0, st)
    wr(IDX_CONTROL_ONE, 8'h00);
    u_dbgc_core_model.sec <= 1'b0;
    wr(IDX_CONTROL_ONE, 8'hF0);
    watch(4);
    `CHK("fire_trace", 1'b1, st)
    wr(IDX_CONTROL_ONE, 8'h00);
    $display("t_fire done");
  endtask

  task automatic t_bdm();
    cfg(2'h2, 8'h01, 18'h00300);
    hit(18'h00300, 16'h0000, 1'b1, 1'b1, 1'b0);
    `CHK("c_unarmed", 3'h0, mo)
    wr(IDX_CONTROL_ONE, 8'h82);
    u_dbgc_core_model.halted <= 1'b1;
    hit(18'h00300, 16'h0000, 1'b1, 1'b1, 1'b0);
    `CHK("c_halted", 3'h0, mo)
    u_dbgc_core_model.halted <= 1'b0;
    hit(18'h00300, 16'h0000, 1'b0, 1'b1, 1'b0);
    `CHK("c_map", 3'h4, mo)
    wr(IDX_CONTROL_ONE, 8'h02);
    $display("t_bdm done");
  endtask

  task automatic t_tag();
    cfg(2'h0, 8'h03, 18'h00400);
    wr(IDX_CONTROL_ONE, 8'hA0);
    hit(18'h00400, 16'h0000, 1'b1, 1'b0, 1'b1);
    watch(6);
    `CHK("tag_no_exec", 1'b0, final_state)
    u_dbgc_core_model.exec_en <= 1'b1;
    hit(18'h00400, 16'h0000, 1'b1, 1'b0, 1'b1);
    watch(6);
    `CHK("tag_exec", 1'b1, final_state)
    `CHK("tag_brk", 1'b1, sb)
    u_dbgc_core_model.exec_en <= 1'b0;
    wr(IDX_CONTROL_ONE, 8'h00);
    $display("t_tag done");
  endtask

  task automatic t_range();
    cfg(2'h0, 8'h01, 18'h00010);
    cfg(2'h1, 8'h01, 18'h00020);
    wr(IDX_CONTROL_TWO, 8'h01);
    wr(IDX_CONTROL_ONE, 8'h80);
    hit(18'h00018, 16'h0000, 1'b1, 1'b1, 1'b0);
    `CHK("range_in", 1'b1, mo[0])
    hit(18'h00030, 16'h0000, 1'b1, 1'b1, 1'b0);
    `CHK("range_out", 1'b0, mo[0])
    wr(IDX_CONTROL_ONE, 8'h00);
    $display("t_range done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_data();
    t_qual();
    t_fire();
    t_bdm();
    t_tag();
    t_range();
    end_sim();
  end
endmodule
bind dbgc_top dbgc_monitor u_dbgc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_valid(core_valid), .core_fetch(core_fetch), .core_bdm_active(core_bdm_active),
  .core_secure(core_secure), .core_taghit(core_taghit), .tag_attach(tag_attach),
  .match_out(match_out), .final_state(final_state), .breakpoint_req(breakpoint_req),
  .trace_start(trace_start));
`default_nettype wire
